//--- inc/icfg_cfg.svh
// Purpose: Offsets, field positions, reset values and timing figures of the input clock monitor block
// Assumes: 100 MHz system clock, 16-bit register addresses, 8-bit register data
// Notes:   Definitions only
`ifndef ICFG_CFG_SVH
`define ICFG_CFG_SVH

`define ICFG_CLK_PERIOD_NS    10
`define ICFG_NS_PER_MS        1000000

`define ICFG_OFS_XTAL_STAT    16'h000c
`define ICFG_OFS_LIVE_STAT    16'h000d
`define ICFG_OFS_LOCK_STAT    16'h000e
`define ICFG_OFS_XTAL_STICKY  16'h0011
`define ICFG_OFS_STICKY       16'h0012
`define ICFG_OFS_IRQ_MASK     16'h0018
`define ICFG_OFS_MON_EN       16'h002c
`define ICFG_OFS_QUAL_TIME    16'h002d
`define ICFG_OFS_THR_A_LO     16'h002e
`define ICFG_OFS_THR_A_HI     16'h002f
`define ICFG_OFS_THR_B_LO     16'h0030
`define ICFG_OFS_THR_B_HI     16'h0031
`define ICFG_OFS_OUT_KEEP     16'h0100
`define ICFG_OFS_SWITCH       16'h0536
`define ICFG_OFS_IN_CTRL      16'h0949

`define ICFG_XTAL_BIT         1
`define ICFG_LOCK_BIT         1
`define ICFG_HSW_BIT          2
`define ICFG_KEEP_BIT         0
`define ICFG_PULSED_LSB       4

`define ICFG_IN_CTRL_RST      8'h03
`define ICFG_SWITCH_RST       8'h00
`define ICFG_MON_EN_RST       2'h3
`define ICFG_QUAL_TIME_RST    4'h0
`define ICFG_IRQ_MASK_RST     2'h3
`define ICFG_GAP_THR_RST      16'h0100
`define ICFG_XTAL_GAP_THR     16'h0040

`define ICFG_QUAL_T0_MS       2
`define ICFG_QUAL_T1_MS       100
`define ICFG_QUAL_T2_MS       200
`define ICFG_QUAL_T3_MS       1000

`endif

//--- inc/icfg_pkg.sv
// Purpose: Types shared by the input clock monitor block
// Assumes: icfg_cfg.svh on the include path
// Notes:   State of each module is one packed struct
`default_nettype none
package icfg_pkg;
   `include "icfg_cfg.svh"

   typedef enum logic [1:0] {MON_ABSENT, MON_QUAL, MON_PRESENT} icfg_mon_fsm_type;

   typedef struct packed {
      logic             s1;
      logic             s2;
      logic             prev;
      icfg_mon_fsm_type fsm;
      logic [15:0]      gap_cnt;
      logic [26:0]      qual_cnt;
   } icfg_mon_state_type;

   typedef struct packed {
      logic [7:0]  in_ctrl;
      logic [7:0]  sw_ctrl;
      logic [1:0]  mon_en;
      logic [3:0]  qual_sel;
      logic [1:0]  irq_mask;
      logic [15:0] thr_a;
      logic [15:0] thr_b;
      logic        keep;
      logic [1:0]  sticky;
      logic        xtal_sticky;
      logic        lock_s1;
      logic        lock_s2;
      logic [7:0]  rdata;
   } icfg_top_state_type;
endpackage : icfg_pkg
`default_nettype wire

//--- inc/icfg_mon_if.sv
// Purpose: Carrier between the register side and one signal-loss monitor
// Assumes: Driven and read on SYS_CLK
// Notes:   None
`timescale 1ns/1ps
`default_nettype none
interface icfg_mon_if;
   logic        enable;
   logic [15:0] gap_thr;
   logic [26:0] qual_cycles;
   logic        absent;
   modport mon (input enable, input gap_thr, input qual_cycles, output absent);
   modport ctl (output enable, output gap_thr, output qual_cycles, input absent);
endinterface : icfg_mon_if
`default_nettype wire

//--- design/icfg_los_mon.sv
// Purpose: Signal-loss monitor for one clock, by gap measurement in system clocks
// Assumes: clk_pin is an activity toggle slow enough to be seen at 100 MHz
// Notes:   Absent from reset until a clock has qualified
`timescale 1ns/1ps
`default_nettype none
module icfg_los_mon (
   input  wire logic SYS_CLK,
   input  wire logic RST_B,
   input  wire logic clk_pin,
   icfg_mon_if.mon   mif
);
   import icfg_pkg::*;

   icfg_mon_state_type s;
   icfg_mon_state_type next_s;
   logic               edge_seen;
   logic               trip;

   assign edge_seen = s.s2 ^ s.prev;
   assign trip      = s.gap_cnt > mif.gap_thr;

   always_comb begin
      next_s      = s;
      next_s.s1   = clk_pin;
      next_s.s2   = s.s1;
      next_s.prev = s.s2;
      if (edge_seen) begin
         next_s.gap_cnt = 16'h0000;
      end else if (s.gap_cnt != 16'hffff) begin
         next_s.gap_cnt = s.gap_cnt + 16'h0001;
      end
      if (!mif.enable) begin
         // A powered-down input never counts as a valid clock
         next_s.fsm      = MON_ABSENT;
         next_s.qual_cnt = '0;
      end else begin
         unique case (s.fsm)
            MON_ABSENT: begin
               next_s.qual_cnt = '0;
               if (edge_seen) begin
                  next_s.fsm = MON_QUAL;
               end
            end
            MON_QUAL: begin
               // Clear only after an unbroken valid run of the chosen length
               if (trip) begin
                  next_s.fsm = MON_ABSENT;
               end else if (s.qual_cnt >= mif.qual_cycles) begin
                  next_s.fsm = MON_PRESENT;
               end else begin
                  next_s.qual_cnt = s.qual_cnt + 27'h0000001;
               end
            end
            MON_PRESENT: begin
               // Gaps shorter than the threshold pass, so gapped clocks stay present
               if (trip) begin
                  next_s.fsm = MON_ABSENT;
               end
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         s <= '{fsm: MON_ABSENT, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign mif.absent = (s.fsm != MON_PRESENT);

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);

   chk_gap_trip_loss: assert property (
      (s.fsm == MON_PRESENT && trip && mif.enable) |=> mif.absent)
      else $error("monitor stayed present after a gap above threshold");
   chk_qual_clear_time: assert property (
      $fell(mif.absent) |-> $past(s.qual_cnt) >= $past(mif.qual_cycles))
      else $error("loss cleared before the qualification time");
   cov_mon_qualified: cover property ($fell(mif.absent));
endmodule : icfg_los_mon
`default_nettype wire

//--- design/icfg_top.sv
// Purpose: Input buffer control, switch control and signal-loss status for two reference inputs
// Assumes: Registers reached through a decoded serial-port strobe interface
// Notes:   Long qualification counts are parameters so simulations can shorten them
`timescale 1ns/1ps
`default_nettype none
`include "icfg_cfg.svh"
// Operation
// - One buffer enable per input at bits 1:0 of input control, 1 enables.
// - Both buffer enables come up set; clearing one powers that input down.
// - Bits 5:4 pick receiver per input: 0 differential, 1 pulsed; reset differential.
// - Hitless bit 2 of switch register: 1 absorbs phase step, 0 passes it.
// - Hitless switching works down to the 8 kHz minimum input frequency.
// - Switching between inputs up to 500 ppm apart never makes runt pulses.
// - PLL pulls in at normal bandwidth, or fast bandwidth when enabled.
// - Lock-loss indicator may assert while pulling in to a new input.
// - Locks to gapped inputs of 10 MHz, at most two of eight missing.
// - Properly configured gapped input raises no loss, range or lock fault.
// - Switching during a gap may exceed the 1.5 ns phase transient.
// - Monitor both inputs and crystal reference; flag lock loss of the PLL.
// - Each loss monitor checks every period, with its own sensitivity.
// - Each monitor has a live bit and a sticky bit held until cleared.
// - Outputs stop on crystal reference loss unless configured to keep running.
// - Live loss status sits at status bits 1:0, one per input.
// - Writing zero clears a sticky bit; a present fault keeps it set.
// - Unmasked signal-loss event on an input raises the interrupt pin.
// - Loss clears only after valid clock for 2 ms, 100 ms, 200 ms or 1 s.
module icfg_top #(
   parameter int unsigned QUAL_CYC_0 = `ICFG_QUAL_T0_MS * (`ICFG_NS_PER_MS / `ICFG_CLK_PERIOD_NS),
   parameter int unsigned QUAL_CYC_1 = `ICFG_QUAL_T1_MS * (`ICFG_NS_PER_MS / `ICFG_CLK_PERIOD_NS),
   parameter int unsigned QUAL_CYC_2 = `ICFG_QUAL_T2_MS * (`ICFG_NS_PER_MS / `ICFG_CLK_PERIOD_NS),
   parameter int unsigned QUAL_CYC_3 = `ICFG_QUAL_T3_MS * (`ICFG_NS_PER_MS / `ICFG_CLK_PERIOD_NS)
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RST_B,
   input  wire logic [15:0] REG_ADDR,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [7:0]  REG_WDATA,
   output var  logic [7:0]  REG_RDATA,
   input  wire logic        INPUT_A_PIN,
   input  wire logic        INPUT_B_PIN,
   input  wire logic        XTAL_REF_PIN,
   input  wire logic        LOCK_MISSING_IN,
   output var  logic [1:0]  INPUT_BUF_EN,
   output var  logic [1:0]  RX_PULSED_SEL,
   output var  logic        PHASE_ABSORB_SWITCH_ON,
   output var  logic [1:0]  INPUT_VALID,
   output var  logic        OUT_CLK_EN,
   output var  logic        IRQ_PIN
);
   import icfg_pkg::*;

   if (QUAL_CYC_0 == 0 || QUAL_CYC_1 == 0 || QUAL_CYC_2 == 0 || QUAL_CYC_3 == 0) begin : g_qual_zero
      $error("qualification counts must be nonzero");
   end
   if (QUAL_CYC_0 >= 32'h08000000 || QUAL_CYC_1 >= 32'h08000000 ||
       QUAL_CYC_2 >= 32'h08000000 || QUAL_CYC_3 >= 32'h08000000) begin : g_qual_wide
      $error("qualification counts exceed the 27-bit counter");
   end

   icfg_top_state_type s;
   icfg_top_state_type next_s;
   logic [1:0]         live;
   logic [1:0]         mon_on;
   logic               xtal_live;
   logic [7:0]         rd_mux;
   logic [1:0]         keep_mask;
   logic               xtal_keep;

   icfg_mon_if mon_a ();
   icfg_mon_if mon_b ();
   icfg_mon_if mon_x ();

   function automatic logic [26:0] qual_cycles(input logic [1:0] sel);
      logic [26:0] cyc;
      unique case (sel)
         2'h0: cyc = QUAL_CYC_0[26:0];
         2'h1: cyc = QUAL_CYC_1[26:0];
         2'h2: cyc = QUAL_CYC_2[26:0];
         2'h3: cyc = QUAL_CYC_3[26:0];
      endcase
      return cyc;
   endfunction : qual_cycles

   // Set wins over a clear that lands in the same cycle
   function automatic logic [1:0] sticky_update(input logic [1:0] cur, input logic [1:0] keep,
                                                input logic [1:0] set);
      return (cur & keep) | set;
   endfunction : sticky_update

   // A monitor runs only while its input buffer is powered
   assign mon_on = s.mon_en & s.in_ctrl[1:0];
   assign live   = {mon_b.absent, mon_a.absent};
   assign xtal_live = mon_x.absent;

   assign mon_a.enable      = mon_on[0];
   assign mon_a.gap_thr     = s.thr_a;
   assign mon_a.qual_cycles = qual_cycles(s.qual_sel[1:0]);
   assign mon_b.enable      = mon_on[1];
   assign mon_b.gap_thr     = s.thr_b;
   assign mon_b.qual_cycles = qual_cycles(s.qual_sel[3:2]);
   // Reference monitor is always on; its threshold is fixed
   assign mon_x.enable      = 1'b1;
   assign mon_x.gap_thr     = `ICFG_XTAL_GAP_THR;
   assign mon_x.qual_cycles = qual_cycles(2'h0);

   icfg_los_mon u_mon_a (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .clk_pin(INPUT_A_PIN), .mif(mon_a.mon));
   icfg_los_mon u_mon_b (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .clk_pin(INPUT_B_PIN), .mif(mon_b.mon));
   icfg_los_mon u_mon_x (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .clk_pin(XTAL_REF_PIN), .mif(mon_x.mon));

   always_comb begin
      rd_mux = 8'h00;
      case (REG_ADDR)
         `ICFG_OFS_XTAL_STAT:   rd_mux[`ICFG_XTAL_BIT] = xtal_live;
         `ICFG_OFS_LIVE_STAT:   rd_mux[1:0] = live;
         `ICFG_OFS_LOCK_STAT:   rd_mux[`ICFG_LOCK_BIT] = s.lock_s2;
         `ICFG_OFS_XTAL_STICKY: rd_mux[`ICFG_XTAL_BIT] = s.xtal_sticky;
         `ICFG_OFS_STICKY:      rd_mux[1:0] = s.sticky;
         `ICFG_OFS_IRQ_MASK:    rd_mux[1:0] = s.irq_mask;
         `ICFG_OFS_MON_EN:      rd_mux[1:0] = s.mon_en;
         `ICFG_OFS_QUAL_TIME:   rd_mux[3:0] = s.qual_sel;
         `ICFG_OFS_THR_A_LO:    rd_mux = s.thr_a[7:0];
         `ICFG_OFS_THR_A_HI:    rd_mux = s.thr_a[15:8];
         `ICFG_OFS_THR_B_LO:    rd_mux = s.thr_b[7:0];
         `ICFG_OFS_THR_B_HI:    rd_mux = s.thr_b[15:8];
         `ICFG_OFS_OUT_KEEP:    rd_mux[`ICFG_KEEP_BIT] = s.keep;
         `ICFG_OFS_SWITCH:      rd_mux = s.sw_ctrl;
         `ICFG_OFS_IN_CTRL:     rd_mux = s.in_ctrl;
         default:               rd_mux = 8'h00;
      endcase
   end

   always_comb begin
      next_s         = s;
      next_s.lock_s1 = LOCK_MISSING_IN;
      next_s.lock_s2 = s.lock_s1;
      keep_mask      = 2'h3;
      xtal_keep      = 1'b1;
      if (REG_WR) begin
         case (REG_ADDR)
            `ICFG_OFS_IN_CTRL:     next_s.in_ctrl = REG_WDATA;
            `ICFG_OFS_SWITCH:      next_s.sw_ctrl = REG_WDATA;
            `ICFG_OFS_MON_EN:      next_s.mon_en = REG_WDATA[1:0];
            `ICFG_OFS_QUAL_TIME:   next_s.qual_sel = REG_WDATA[3:0];
            `ICFG_OFS_IRQ_MASK:    next_s.irq_mask = REG_WDATA[1:0];
            `ICFG_OFS_THR_A_LO:    next_s.thr_a[7:0] = REG_WDATA;
            `ICFG_OFS_THR_A_HI:    next_s.thr_a[15:8] = REG_WDATA;
            `ICFG_OFS_THR_B_LO:    next_s.thr_b[7:0] = REG_WDATA;
            `ICFG_OFS_THR_B_HI:    next_s.thr_b[15:8] = REG_WDATA;
            `ICFG_OFS_OUT_KEEP:    next_s.keep = REG_WDATA[`ICFG_KEEP_BIT];
            `ICFG_OFS_STICKY:      keep_mask = REG_WDATA[1:0];
            `ICFG_OFS_XTAL_STICKY: xtal_keep = REG_WDATA[`ICFG_XTAL_BIT];
            default:               next_s.keep = s.keep;
         endcase
      end
      // A lasting fault re-sets the bit, so a clear only sticks once it is gone
      next_s.sticky = sticky_update(s.sticky, keep_mask, live & mon_on);
      next_s.xtal_sticky = (s.xtal_sticky & xtal_keep) | xtal_live;
      if (REG_RD) begin
         next_s.rdata = rd_mux;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         s.in_ctrl     <= `ICFG_IN_CTRL_RST;
         s.sw_ctrl     <= `ICFG_SWITCH_RST;
         s.mon_en      <= `ICFG_MON_EN_RST;
         s.qual_sel    <= `ICFG_QUAL_TIME_RST;
         s.irq_mask    <= `ICFG_IRQ_MASK_RST;
         s.thr_a       <= `ICFG_GAP_THR_RST;
         s.thr_b       <= `ICFG_GAP_THR_RST;
         s.keep        <= 1'b0;
         s.sticky      <= 2'h0;
         s.xtal_sticky <= 1'b0;
         s.lock_s1     <= 1'b0;
         s.lock_s2     <= 1'b0;
         s.rdata       <= 8'h00;
      end else begin
         s <= next_s;
      end
   end

   // The PLL core does the phase absorption, pull-in and glitchless hand-over;
   // this block only hands it the enable and keeps the input status honest
   assign INPUT_BUF_EN           = s.in_ctrl[1:0];
   assign RX_PULSED_SEL          = s.in_ctrl[`ICFG_PULSED_LSB +: 2];
   assign PHASE_ABSORB_SWITCH_ON = s.sw_ctrl[`ICFG_HSW_BIT];
   assign INPUT_VALID            = ~live;
   assign OUT_CLK_EN             = ~(xtal_live & ~s.keep);
   assign IRQ_PIN                = |(s.sticky & ~s.irq_mask);
   assign REG_RDATA              = s.rdata;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);

   chk_buf_en_reset: assert property ($rose(RST_B) |-> INPUT_BUF_EN == 2'h3 && RX_PULSED_SEL == 2'h0)
      else $error("input buffers not enabled after reset");
   chk_buf_en_write: assert property (
      (REG_WR && REG_ADDR == `ICFG_OFS_IN_CTRL) |=> INPUT_BUF_EN == $past(REG_WDATA[1:0]))
      else $error("buffer enables did not follow the write");
   chk_receiver_type: assert property (
      (REG_WR && REG_ADDR == `ICFG_OFS_IN_CTRL) |=> RX_PULSED_SEL == $past(REG_WDATA[5:4]))
      else $error("receiver selection did not follow the write");
   chk_hitless_write: assert property (
      (REG_WR && REG_ADDR == `ICFG_OFS_SWITCH) |=> PHASE_ABSORB_SWITCH_ON == $past(REG_WDATA[2]))
      else $error("phase absorb enable did not follow the write");
   chk_live_read: assert property (
      (REG_RD && REG_ADDR == `ICFG_OFS_LIVE_STAT) |=> REG_RDATA == {6'h00, $past(live)})
      else $error("live status read wrong");
   chk_sticky_hold: assert property (
      (s.sticky[0] && !(REG_WR && REG_ADDR == `ICFG_OFS_STICKY)) |=> s.sticky[0])
      else $error("sticky bit dropped without a clear");
   chk_sticky_fault_stays: assert property (
      (live[0] && mon_on[0]) |=> s.sticky[0])
      else $error("present fault did not hold the sticky bit");
   chk_disabled_quiet: assert property (
      (!mon_on[0] && !s.sticky[0]) |=> !s.sticky[0] && !INPUT_VALID[0])
      else $error("powered-down input raised an event or looked valid");
   chk_out_gate: assert property (
      (xtal_live && !s.keep) |-> !OUT_CLK_EN)
      else $error("outputs ran during reference loss");
   chk_out_keep: assert property (
      (REG_WR && REG_ADDR == `ICFG_OFS_OUT_KEEP && REG_WDATA[`ICFG_KEEP_BIT]) |=> OUT_CLK_EN)
      else $error("outputs stopped although the keep bit was set");
   chk_irq_raise: assert property (
      (live[1] && mon_on[1] && !s.irq_mask[1]) |=> IRQ_PIN)
      else $error("unmasked loss did not raise the interrupt");

   cov_sticky_clear: cover property (s.sticky[0] ##1 !s.sticky[0]);
   cov_irq_seen: cover property ($rose(IRQ_PIN));
   cov_out_stop: cover property ($fell(OUT_CLK_EN));
endmodule : icfg_top
`default_nettype wire

//--- verification/icfg_clk_src.sv
// Purpose: Far-side model of the two reference inputs and the crystal reference, as activity toggles
// Assumes: One shared half-period counter for all three sources
// Notes:   A stopped source holds its level, as a real dead clock does
`timescale 1ns/1ps
`default_nettype none
module icfg_clk_src #(
   parameter int unsigned HALF = 4
) (
   input  wire logic       SYS_CLK,
   input  wire logic [2:0] run,
   output var  logic [2:0] pins
);
   int unsigned cnt = 0;
   logic [2:0]  lvl = 3'h0;

   assign pins = lvl;

   // One counter keeps both inputs frequency locked
   // Sources are integer-divided toggles; no fractional pre-divider is modelled
   always @(posedge SYS_CLK) begin
      if (cnt == HALF - 1) begin
         cnt <= 0;
         lvl <= lvl ^ run;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : icfg_clk_src
`default_nettype wire

//--- verification/icfg_top_tb.sv
// Purpose: Self-checking bench of the input clock monitor block through its register strobes
// Assumes: Qualification counts shortened to 20/40/60/80 cycles
// Notes:   Input thresholds lowered to 0x20 so losses trip quickly
`timescale 1ns/1ps
`default_nettype none
module icfg_top_tb;
   import icfg_pkg::*;

   logic        sys_clk;
   logic        rst_b;
   logic [15:0] reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic [2:0]  run;
   logic [2:0]  pins;
   logic        lock_missing;
   logic [1:0]  input_buf_en;
   logic [1:0]  rx_pulsed_sel;
   logic        phase_absorb_switch_on;
   logic [1:0]  input_valid;
   logic        out_clk_en;
   logic        irq_pin;
   int          fails;
   int          comparisons;

   icfg_top #(.QUAL_CYC_0(20), .QUAL_CYC_1(40), .QUAL_CYC_2(60), .QUAL_CYC_3(80)) icfg_top_inst (
      .SYS_CLK                (sys_clk),
      .RST_B                  (rst_b),
      .REG_ADDR               (reg_addr),
      .REG_WR                 (reg_wr),
      .REG_RD                 (reg_rd),
      .REG_WDATA              (reg_wdata),
      .REG_RDATA              (reg_rdata),
      .INPUT_A_PIN            (pins[0]),
      .INPUT_B_PIN            (pins[1]),
      .XTAL_REF_PIN           (pins[2]),
      .LOCK_MISSING_IN        (lock_missing),
      .INPUT_BUF_EN           (input_buf_en),
      .RX_PULSED_SEL          (rx_pulsed_sel),
      .PHASE_ABSORB_SWITCH_ON (phase_absorb_switch_on),
      .INPUT_VALID            (input_valid),
      .OUT_CLK_EN             (out_clk_en),
      .IRQ_PIN                (irq_pin)
   );

   icfg_clk_src #(.HALF(4)) icfg_clk_src_inst (
      .SYS_CLK (sys_clk),
      .run     (run),
      .pins    (pins)
   );

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic stop_test;
      if (fails == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [15:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      #1;
      reg_wr    = 1'b1;
      reg_addr  = addr;
      reg_wdata = data;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] addr, input logic [7:0] mask, input logic [7:0] exp);
      @(posedge sys_clk);
      #1;
      reg_rd   = 1'b1;
      reg_addr = addr;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      check(reg_rdata & mask, exp);
   endtask : rd

   initial begin
      #200000;
      fails++;
      stop_test();
   end

   initial begin
      fails        = 0;
      comparisons  = 0;
      rst_b        = 1'b0;
      reg_addr     = 16'h0000;
      reg_wr       = 1'b0;
      reg_rd       = 1'b0;
      reg_wdata    = 8'h00;
      run          = 3'h0;
      lock_missing = 1'b0;
      cyc(10);
      rst_b = 1'b1;
      // Defaults after reset
      check({6'h00, input_buf_en}, 8'h03);
      check({6'h00, rx_pulsed_sel}, 8'h00);
      check({7'h00, phase_absorb_switch_on}, 8'h00);
      check({7'h00, irq_pin}, 8'h00);
      rd(16'h0949, 8'hff, 8'h03);
      rd(16'h0536, 8'h04, 8'h00);
      rd(16'h0018, 8'h03, 8'h03);
      // Buffer and receiver fields move independently
      wr(16'h0949, 8'h31);
      check({6'h00, input_buf_en}, 8'h01);
      check({6'h00, rx_pulsed_sel}, 8'h03);
      rd(16'h0949, 8'h33, 8'h31);
      wr(16'h0949, 8'h22);
      check({6'h00, input_buf_en}, 8'h02);
      check({6'h00, rx_pulsed_sel}, 8'h02);
      wr(16'h0949, 8'h03);
      wr(16'h0536, 8'h04);
      check({7'h00, phase_absorb_switch_on}, 8'h01);
      wr(16'h0536, 8'h00);
      check({7'h00, phase_absorb_switch_on}, 8'h00);
      // Unmapped place reads zero and ignores writes
      wr(16'h0123, 8'h5a);
      rd(16'h0123, 8'hff, 8'h00);
      // Per-input thresholds and qualification codes 0 and 3
      wr(16'h002e, 8'h20);
      wr(16'h002f, 8'h00);
      wr(16'h0030, 8'h20);
      wr(16'h0031, 8'h00);
      wr(16'h002d, 8'h0c);
      rd(16'h002d, 8'h0f, 8'h0c);
      run = 3'h7;
      cyc(45);
      check({6'h00, input_valid}, 8'h01);
      cyc(85);
      check({6'h00, input_valid}, 8'h03);
      check({7'h00, out_clk_en}, 8'h01);
      rd(16'h000d, 8'h03, 8'h00);
      wr(16'h0012, 8'h00);
      wr(16'h0011, 8'h00);
      rd(16'h0012, 8'h03, 8'h00);
      // A short gap is below the sensitivity and is ignored
      run = 3'h6;
      cyc(12);
      run = 3'h7;
      cyc(40);
      check({6'h00, input_valid}, 8'h03);
      rd(16'h0012, 8'h03, 8'h00);
      // Input a dies: live, sticky, masked then unmasked interrupt
      run = 3'h6;
      cyc(60);
      check({6'h00, input_valid}, 8'h02);
      rd(16'h000d, 8'h03, 8'h01);
      rd(16'h0012, 8'h03, 8'h01);
      check({7'h00, irq_pin}, 8'h00);
      wr(16'h0018, 8'h02);
      check({7'h00, irq_pin}, 8'h01);
      wr(16'h0012, 8'h00);
      rd(16'h0012, 8'h03, 8'h01);
      run = 3'h7;
      cyc(60);
      rd(16'h000d, 8'h03, 8'h00);
      rd(16'h0012, 8'h03, 8'h01);
      wr(16'h0012, 8'h01);
      rd(16'h0012, 8'h03, 8'h01);
      wr(16'h0012, 8'h00);
      rd(16'h0012, 8'h03, 8'h00);
      check({7'h00, irq_pin}, 8'h00);
      // Powered-down input is never valid and raises no sticky event
      wr(16'h0018, 8'h00);
      wr(16'h0949, 8'h01);
      cyc(10);
      check({6'h00, input_valid}, 8'h01);
      rd(16'h000d, 8'h02, 8'h02);
      rd(16'h0012, 8'h03, 8'h00);
      check({7'h00, irq_pin}, 8'h00);
      wr(16'h0949, 8'h03);
      cyc(120);
      check({6'h00, input_valid}, 8'h03);
      wr(16'h0018, 8'h03);
      // Reference loss stops outputs unless the keep bit is set
      run = 3'h3;
      cyc(100);
      check({7'h00, out_clk_en}, 8'h00);
      rd(16'h000c, 8'h02, 8'h02);
      rd(16'h0011, 8'h02, 8'h02);
      wr(16'h0100, 8'h01);
      check({7'h00, out_clk_en}, 8'h01);
      run = 3'h7;
      cyc(60);
      rd(16'h000c, 8'h02, 8'h00);
      rd(16'h0011, 8'h02, 8'h02);
      // Lock-loss level reaches its status bit
      lock_missing = 1'b1;
      cyc(4);
      rd(16'h000e, 8'h02, 8'h02);
      lock_missing = 1'b0;
      cyc(4);
      rd(16'h000e, 8'h02, 8'h00);
      // Mid-run reset returns registers and monitors to their defaults
      rst_b = 1'b0;
      cyc(2);
      rst_b = 1'b1;
      check({7'h00, out_clk_en}, 8'h00);
      check({6'h00, input_valid}, 8'h00);
      rd(16'h0100, 8'h01, 8'h00);
      rd(16'h0949, 8'hff, 8'h03);
      stop_test();
   end
endmodule : icfg_top_tb
`default_nettype wire
